// [core/afs_core.sv]
// switch matrix, pin sharing and comparator control for the analog front end
// assumes avalon-mm master with waitrequest and comparator results synchronous-able
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/10ps
module afs_core
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // comparator raw results
  input wire logic cmp_a_result,
  input wire logic cmp_b_result,
  // analog side
  output afs_pkg::afs_analog_t analog,
  output afs_pkg::afs_pins_t pins,
  output logic [1:0] irq_req
);
  import afs_pkg::*;

  typedef struct packed {
    afs_cmp_t ca;
    afs_cmp_t cb;
    logic sps;
    logic [1:0] edge_sel;
    logic [6:0] amp;
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] irq;
    afs_bus_t bus;
    logic [31:0] rdata;
    logic [1:0] resp;
    afs_analog_t an;
    afs_pins_t pn;
  } afs_state_t;

  afs_state_t st_q;
  afs_state_t st_d;

  // edge detect per selected mode
  function automatic logic afs_edge(input logic [1:0] mode, input logic now, input logic was);
    case (mode)
      AFS_EDGE_RISE: afs_edge = now & ~was;
      AFS_EDGE_FALL: afs_edge = ~now & was;
      AFS_EDGE_BOTH: afs_edge = now ^ was;
      default: afs_edge = 1'b0;
    endcase
  endfunction : afs_edge

  logic sps_eff;
  logic a_sel_eff;
  logic b_sel_eff;
  logic [7:0] rd8;
  logic [1:0] ev;
  logic hit;

  always_comb
  begin
    st_d = st_q;
    sps_eff = st_q.sps | st_q.ca.cal_mode | st_q.cb.cal_mode;
    a_sel_eff = st_q.ca.sel | st_q.ca.cal_mode;
    b_sel_eff = st_q.cb.sel | st_q.cb.cal_mode;
    // synchronisers; only stage 2 and 3 are used
    st_d.s1 = {cmp_b_result, cmp_a_result};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    ev[0] = afs_edge(st_q.edge_sel, st_q.s2[0], st_q.s3[0]) & st_q.ca.int_en & st_q.ca.en;
    ev[1] = afs_edge(st_q.edge_sel, st_q.s2[1], st_q.s3[1]) & st_q.cb.int_en & st_q.cb.en;
    hit = 1'b1;
    rd8 = 8'h00;
    case (address)
      AFS_A_CAL: rd8 = {st_q.s2[0], st_q.ca.cal_mode, st_q.ca.cal_ref, st_q.ca.trim};
      AFS_A_PATH: rd8 = {sps_eff, 3'h0, st_q.ca.int_en, st_q.ca.out_en, a_sel_eff,
                         st_q.ca.en};
      AFS_B_CAL: rd8 = {st_q.s2[1], st_q.cb.cal_mode, st_q.cb.cal_ref, st_q.cb.trim};
      AFS_B_PATH: rd8 = {st_q.edge_sel, 2'h0, st_q.cb.int_en, st_q.cb.out_en, b_sel_eff,
                         st_q.cb.en};
      AFS_AMP_CTRL: rd8 = {1'b0, st_q.amp};
      AFS_IRQ_STAT: rd8 = {6'h00, st_q.irq};
      default: hit = 1'b0;
    endcase
    // irq flags: set wins over clear
    if (write && st_q.bus == AFS_IDLE && address == AFS_IRQ_STAT)
      st_d.irq = st_q.irq & ~writedata[1:0];
    st_d.irq = st_d.irq | ev;
    case (st_q.bus)
      AFS_IDLE:
      begin
        if (read || write)
        begin
          st_d.bus = AFS_DONE;
          st_d.resp = hit ? 2'h0 : 2'h2;
          st_d.rdata = {24'h000000, rd8};
          if (write)
          begin
            case (address)
              AFS_A_CAL:
              begin
                st_d.ca.cal_mode = writedata[AFS_CALM_BIT];
                st_d.ca.cal_ref = writedata[AFS_CREF_BIT];
                st_d.ca.trim = writedata[4:0];
              end
              AFS_A_PATH:
              begin
                st_d.sps = writedata[AFS_SPS_BIT];
                st_d.ca.int_en = writedata[AFS_IE_BIT];
                st_d.ca.out_en = writedata[AFS_OE_BIT];
                st_d.ca.sel = writedata[AFS_SEL_BIT];
                st_d.ca.en = writedata[AFS_EN_BIT];
              end
              AFS_B_CAL:
              begin
                st_d.cb.cal_mode = writedata[AFS_CALM_BIT];
                st_d.cb.cal_ref = writedata[AFS_CREF_BIT];
                st_d.cb.trim = writedata[4:0];
              end
              AFS_B_PATH:
              begin
                st_d.edge_sel = writedata[AFS_ES_HI:AFS_ES_LO];
                st_d.cb.int_en = writedata[AFS_IE_BIT];
                st_d.cb.out_en = writedata[AFS_OE_BIT];
                st_d.cb.sel = writedata[AFS_SEL_BIT];
                st_d.cb.en = writedata[AFS_EN_BIT];
              end
              AFS_AMP_CTRL: st_d.amp = writedata[6:0];
              default: st_d.amp = st_q.amp;
            endcase
          end
        end
      end
      AFS_DONE: st_d.bus = AFS_IDLE;
      default: st_d.bus = AFS_IDLE;
    endcase
    // gain and feedback only meaningful while amp enabled
    if (!st_d.amp[AFS_AEN_BIT])
    begin
      st_d.amp[AFS_AGN_BIT] = 1'b0;
      st_d.amp[AFS_ABF_BIT] = 1'b0;
    end
    // analog controls
    st_d.an.gain_switch_a = st_q.amp[AFS_AEN_BIT] & st_q.amp[AFS_AGN_BIT];
    st_d.an.gain_switch_b = st_q.amp[AFS_AEN_BIT] & st_q.amp[AFS_AGN_BIT];
    st_d.an.buffer_feedback_switch = st_q.amp[AFS_AEN_BIT] & st_q.amp[AFS_ABF_BIT];
    st_d.an.pin_out_claim = st_q.amp[AFS_AEN_BIT];
    st_d.an.pin_pos_claim = st_q.amp[AFS_AEN_BIT] & st_q.amp[AFS_APS_BIT];
    st_d.an.pin_neg_claim = st_q.amp[AFS_AEN_BIT]
                            & (st_q.amp[AFS_AGN_BIT] | st_q.amp[AFS_ANS_BIT]);
    st_d.an.bypass_resistor = st_q.amp[AFS_AEN_BIT]
                              & st_q.amp[AFS_AGN_BIT] & st_q.amp[AFS_ANS_BIT];
    st_d.an.amp_a_route = st_q.amp[AFS_ARA_BIT] & ~sps_eff;
    st_d.an.amp_b_route = st_q.amp[AFS_ARB_BIT] & ~sps_eff
                          & ~st_q.amp[AFS_ARA_BIT];
    st_d.an.shared_positive_select = sps_eff;
    st_d.an.cmp_a_neg_select = a_sel_eff;
    st_d.an.cmp_b_pos_select = b_sel_eff;
    st_d.an.cmp_a_ref = st_q.ca.cal_ref;
    st_d.an.cmp_b_ref = st_q.cb.cal_ref;
    st_d.an.cmp_a_en = st_q.ca.en;
    st_d.an.cmp_b_en = st_q.cb.en;
    st_d.an.cmp_a_trim = st_q.ca.trim;
    st_d.an.cmp_b_trim = st_q.cb.trim;
    st_d.an.cmp_a_cal = st_q.ca.cal_mode;
    st_d.an.cmp_b_cal = st_q.cb.cal_mode;
    st_d.pn.a_oe = st_q.ca.en & st_q.ca.out_en;
    st_d.pn.a_out = st_q.ca.en & st_q.ca.out_en & st_q.s2[0];
    st_d.pn.b_oe = st_q.cb.en & st_q.cb.out_en;
    st_d.pn.b_out = st_q.cb.en & st_q.cb.out_en & st_q.s2[1];
    if (rst)
    begin
      st_d = '0;
      st_d.ca.trim = AFS_TRIM_RST;
      st_d.cb.trim = AFS_TRIM_RST;
      st_d.ca.sel = AFS_SEL_RST;
      st_d.cb.sel = AFS_SEL_RST;
      st_d.sps = AFS_SEL_RST;
      st_d.amp = AFS_AMP_RST;
      st_d.bus = AFS_IDLE;
    end
  end

  always_ff @(posedge clock)
  begin
    st_q <= st_d;
  end

  always_comb
  begin
    readdata = st_q.rdata;
    waitrequest = ~(st_q.bus == AFS_DONE);
    response = st_q.resp;
    analog = st_q.an;
    pins = st_q.pn;
    irq_req = st_q.irq;
  end

  // checks
  gain_switch_a: assert property (@(posedge clock) disable iff (rst)
    $rose(st_q.amp[AFS_AGN_BIT] & st_q.amp[AFS_AEN_BIT]) |=> analog.gain_switch_a
                                                          && analog.gain_switch_b)
    else $error("gain switches did not close");
  amp_off_a: assert property (@(posedge clock) disable iff (rst)
    !st_q.amp[AFS_AEN_BIT] |=> !analog.pin_out_claim && !analog.gain_switch_a
                               && !analog.buffer_feedback_switch)
    else $error("amplifier off but pins held");
  cal_force_a: assert property (@(posedge clock) disable iff (rst)
    st_q.ca.cal_mode |=> analog.shared_positive_select && analog.cmp_a_neg_select)
    else $error("calibration a did not force selects");
  cal_b_force_a: assert property (@(posedge clock) disable iff (rst)
    st_q.cb.cal_mode |=> analog.shared_positive_select && analog.cmp_b_pos_select)
    else $error("calibration b did not force selects");
  route_block_a: assert property (@(posedge clock) disable iff (rst)
    analog.shared_positive_select |-> !analog.amp_a_route && !analog.amp_b_route)
    else $error("amplifier route open with pin select");
  irq_gate_a: assert property (@(posedge clock) disable iff (rst)
    $rose(irq_req[0]) |-> $past(st_q.ca.int_en))
    else $error("irq a set while disabled");
  irq_none_a: assert property (@(posedge clock) disable iff (rst)
    st_q.edge_sel == AFS_EDGE_NONE && $past(st_q.edge_sel) == AFS_EDGE_NONE
    |-> !$rose(irq_req[1]))
    else $error("irq set with edges disabled");
  bus_ans_a: assert property (@(posedge clock) disable iff (rst)
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  pin_oe_a: assert property (@(posedge clock) disable iff (rst)
    pins.a_oe |-> $past(st_q.ca.en) && $past(st_q.ca.out_en))
    else $error("pin a driven while disabled");
  // amplifier b switches and pins
  gain_open_a: assert property (@(posedge clock) disable iff (rst)
    !st_q.amp[AFS_AGN_BIT]
    |=> !analog.gain_switch_a && !analog.gain_switch_b)
    else $error("gain switches closed without gain");
  fb_switch_a: assert property (@(posedge clock) disable iff (rst)
    analog.buffer_feedback_switch |-> $past(st_q.amp[AFS_AEN_BIT]))
    else $error("feedback switch closed with amplifier off");
  gain_clear_a: assert property (@(posedge clock) disable iff (rst)
    !st_q.amp[AFS_AEN_BIT] |-> !st_q.amp[AFS_AGN_BIT] && !st_q.amp[AFS_ABF_BIT])
    else $error("gain or feedback bit kept with amplifier off");
  amp_off_pins_a: assert property (@(posedge clock) disable iff (rst)
    !st_q.amp[AFS_AEN_BIT] |=> !analog.pin_pos_claim && !analog.pin_neg_claim)
    else $error("input pins claimed with amplifier off");
  out_claim_a: assert property (@(posedge clock) disable iff (rst)
    st_q.amp[AFS_AEN_BIT] |=> analog.pin_out_claim)
    else $error("output pin not claimed");
  pos_claim_a: assert property (@(posedge clock) disable iff (rst)
    analog.pin_pos_claim
    |-> $past(st_q.amp[AFS_AEN_BIT]) && $past(st_q.amp[AFS_APS_BIT]))
    else $error("positive pin claimed without select");
  neg_claim_a: assert property (@(posedge clock) disable iff (rst)
    analog.pin_neg_claim |-> $past(st_q.amp[AFS_AEN_BIT])
    && ($past(st_q.amp[AFS_AGN_BIT]) || $past(st_q.amp[AFS_ANS_BIT])))
    else $error("negative pin claimed without cause");
  bypass_claim_a: assert property (@(posedge clock) disable iff (rst)
    analog.bypass_resistor |-> analog.pin_neg_claim)
    else $error("resistor bypass without negative pin");
  // comparator status and read back
  result_read_a: assert property (@(posedge clock) disable iff (rst)
    read && waitrequest && address == AFS_A_CAL
    |=> readdata[AFS_RES_BIT] == $past(st_q.s2[0]))
    else $error("comparator a result not read back");
  cal_a_read_a: assert property (@(posedge clock) disable iff (rst)
    read && waitrequest && address == AFS_A_PATH && st_q.ca.cal_mode
    |=> readdata[AFS_SPS_BIT] && readdata[AFS_SEL_BIT])
    else $error("forced selects of a not read as one");
  cal_b_read_a: assert property (@(posedge clock) disable iff (rst)
    read && waitrequest && address == AFS_B_PATH && st_q.cb.cal_mode
    |=> readdata[AFS_SEL_BIT])
    else $error("forced select of b not read as one");
  unimpl_a_a: assert property (@(posedge clock) disable iff (rst)
    read && waitrequest && address == AFS_A_PATH |=> readdata[6:4] == 3'h0)
    else $error("unimplemented bits of a not zero");
  unimpl_b_a: assert property (@(posedge clock) disable iff (rst)
    read && waitrequest && address == AFS_B_PATH |=> readdata[5:4] == 2'h0)
    else $error("unimplemented bits of b not zero");
  // comparator analog controls
  ref_a_a: assert property (@(posedge clock) disable iff (rst)
    analog.cmp_a_ref == $past(st_q.ca.cal_ref))
    else $error("reference a not driven");
  ref_b_a: assert property (@(posedge clock) disable iff (rst)
    analog.cmp_b_ref == $past(st_q.cb.cal_ref))
    else $error("reference b not driven");
  cmp_a_en_a: assert property (@(posedge clock) disable iff (rst)
    analog.cmp_a_en == $past(st_q.ca.en))
    else $error("comparator a enable not driven");
  cmp_b_en_a: assert property (@(posedge clock) disable iff (rst)
    analog.cmp_b_en == $past(st_q.cb.en))
    else $error("comparator b enable not driven");
  trim_out_a: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> analog.cmp_a_trim == $past(st_q.ca.trim)
    && analog.cmp_b_trim == $past(st_q.cb.trim))
    else $error("offset trim not driven");
  sps_out_a: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> analog.shared_positive_select
    == $past(st_q.sps | st_q.ca.cal_mode | st_q.cb.cal_mode))
    else $error("shared positive select not driven");
  route_excl_a: assert property (@(posedge clock) disable iff (rst)
    analog.amp_b_route |-> !analog.amp_a_route)
    else $error("both amplifier routes open");
  // output pins and interrupts
  pin_a_val_a: assert property (@(posedge clock) disable iff (rst)
    pins.a_out |-> pins.a_oe)
    else $error("pin a value without enable");
  pin_b_oe_a: assert property (@(posedge clock) disable iff (rst)
    pins.b_oe |-> $past(st_q.cb.en) && $past(st_q.cb.out_en))
    else $error("pin b driven while disabled");
  irq_b_gate_a: assert property (@(posedge clock) disable iff (rst)
    $rose(irq_req[1]) |-> $past(st_q.cb.int_en))
    else $error("irq b set while disabled");
  irq_rise_a: assert property (@(posedge clock) disable iff (rst)
    st_q.edge_sel == AFS_EDGE_RISE && st_q.s2[1] && !st_q.s3[1]
    && st_q.cb.int_en && st_q.cb.en |=> irq_req[1])
    else $error("rising edge missed");
  irq_fall_a: assert property (@(posedge clock) disable iff (rst)
    st_q.edge_sel == AFS_EDGE_FALL && !st_q.s2[1] && st_q.s3[1]
    && st_q.cb.int_en && st_q.cb.en |=> irq_req[1])
    else $error("falling edge missed");
  irq_sticky_a: assert property (@(posedge clock) disable iff (rst)
    irq_req[0] && !(write && address == AFS_IRQ_STAT && writedata[0])
    |=> irq_req[0])
    else $error("irq a flag lost without clear");
  cover_amp_c: cover property (@(posedge clock) analog.bypass_resistor);
  cover_irq_a_c: cover property (@(posedge clock) $rose(irq_req[0]));
  cover_cal_c: cover property (@(posedge clock) $fell(st_q.ca.cal_mode));
  cover_irq_c: cover property (@(posedge clock) $rose(irq_req[1]));
  cover_pin_c: cover property (@(posedge clock) pins.b_oe && pins.b_out);
endmodule : afs_core

// [common/afs_pkg.sv]
// constants and carrier types for the analog front end switch control
// assumes a 50 MHz system clock and an avalon-mm register slave
// Overview of operation
// - gain enable closes both gain switches; cleared opens them.
// - amplifier b disabled opens gain and buffer feedback switches.
// - amplifier b disabled leaves all three shared pins as general i/o.
// - enabled amplifier drives output pin; positive pin taken only if selected.
// - negative pin claimed by gain or select; both bypass input resistor.
// - comparator result reads as bit 7 of first control register.
// - result routes to a pin and raises an edge interrupt request.
// - comparator a calibration forces shared positive and negative selects high.
// - comparator b calibration forces shared positive select high.
// - comparator a reference: negative pin at 0, shared pin at 1.
// - comparator b reference: own positive pin at 0, shared pin at 1.
// - five bit offset trim in bits 4..0, reset 10000, driven out.
// - shared positive select bit 7 picks amplifier or pin, resets 1.
// - comparator a interrupt enable bit 3 gates its request, resets 0.
// - comparator a output pin enable bit 2 drives result onto pin.
// - comparator a negative select bit 1 picks reference or pin, resets 1.
// - comparator a enable bit 0 powers down and releases pins when 0.
// - edge field bits 7..6: none, rising, falling, both.
// - comparator b interrupt enable bit 3 gates its request, resets 0.
// - comparator b output pin enable bit 2 drives result onto pin.
// - comparator b positive select bit 1 picks reference or pin, resets 1.
// - comparator b enable bit 0; unimplemented bits read zero.
// - leaving calibration restores written selects; forced bits read as 1.
// - comparator b calibration forces and reads selects as 1, then restores.
// - shared positive select high forces both amplifier routes to 0.
package afs_pkg;
  // word addresses of the register map
  localparam logic [3:0] AFS_A_CAL = 4'h0;
  localparam logic [3:0] AFS_A_PATH = 4'h1;
  localparam logic [3:0] AFS_B_CAL = 4'h2;
  localparam logic [3:0] AFS_B_PATH = 4'h3;
  localparam logic [3:0] AFS_AMP_CTRL = 4'h4;
  localparam logic [3:0] AFS_IRQ_STAT = 4'h5;
  // field positions
  localparam int AFS_RES_BIT = 7;
  localparam int AFS_CALM_BIT = 6;
  localparam int AFS_CREF_BIT = 5;
  localparam int AFS_SPS_BIT = 7;
  localparam int AFS_ES_HI = 7;
  localparam int AFS_ES_LO = 6;
  localparam int AFS_IE_BIT = 3;
  localparam int AFS_OE_BIT = 2;
  localparam int AFS_SEL_BIT = 1;
  localparam int AFS_EN_BIT = 0;
  // amplifier control: enable, gain, pos pin, neg pin, buffer fb, a route, b route
  localparam int AFS_AEN_BIT = 0;
  localparam int AFS_AGN_BIT = 1;
  localparam int AFS_APS_BIT = 2;
  localparam int AFS_ANS_BIT = 3;
  localparam int AFS_ABF_BIT = 4;
  localparam int AFS_ARA_BIT = 5;
  localparam int AFS_ARB_BIT = 6;
  // reset values
  localparam logic [4:0] AFS_TRIM_RST = 5'h10;
  localparam logic AFS_SEL_RST = 1'b1;
  localparam logic [6:0] AFS_AMP_RST = 7'h0c;
  // edge modes
  localparam logic [1:0] AFS_EDGE_NONE = 2'h0;
  localparam logic [1:0] AFS_EDGE_RISE = 2'h1;
  localparam logic [1:0] AFS_EDGE_FALL = 2'h2;
  localparam logic [1:0] AFS_EDGE_BOTH = 2'h3;
  typedef enum logic [1:0] {AFS_IDLE, AFS_DONE} afs_bus_t;
  // comparator software state
  typedef struct packed {
    logic cal_mode;
    logic cal_ref;
    logic [4:0] trim;
    logic int_en;
    logic out_en;
    logic sel;
    logic en;
  } afs_cmp_t;
  // analog switch and pin controls
  typedef struct packed {
    logic gain_switch_a;
    logic gain_switch_b;
    logic buffer_feedback_switch;
    logic bypass_resistor;
    logic pin_pos_claim;
    logic pin_neg_claim;
    logic pin_out_claim;
    logic amp_a_route;
    logic amp_b_route;
    logic shared_positive_select;
    logic cmp_a_neg_select;
    logic cmp_b_pos_select;
    logic cmp_a_ref;
    logic cmp_b_ref;
    logic cmp_a_en;
    logic cmp_b_en;
    logic [4:0] cmp_a_trim;
    logic [4:0] cmp_b_trim;
    logic cmp_a_cal;
    logic cmp_b_cal;
  } afs_analog_t;
  // pin outputs: value and enable per comparator output pin
  typedef struct packed {
    logic a_out;
    logic a_oe;
    logic b_out;
    logic b_oe;
  } afs_pins_t;
endpackage : afs_pkg

// [verification/afs_far_model.sv]
// far side model: two comparators answering with commanded levels
// assumes the control block drives the comparator enables
`timescale 1ns/10ps
module afs_far_model
(
  // control side
  input wire afs_pkg::afs_analog_t analog,
  // commanded input differences
  input wire logic lvl_a,
  input wire logic lvl_b,
  // comparator outputs
  output logic cmp_a_result,
  output logic cmp_b_result
);
  import afs_pkg::*;
  // powered down comparator answers low
  assign cmp_a_result = analog.cmp_a_en & lvl_a;
  assign cmp_b_result = analog.cmp_b_en & lvl_b;
endmodule : afs_far_model

// [verification/afs_core_tb.sv]
// self-checking bench for the analog front end switch control
// assumes afs_core and afs_far_model, avalon-mm master in this bench
`timescale 1ns/10ps
module afs_core_tb;
  import afs_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  logic cmp_a_result;
  logic cmp_b_result;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  afs_analog_t analog;
  afs_pins_t pins;
  logic [1:0] irq_req;
  logic [31:0] q;
  logic [1:0] r;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  always #10 clock = ~clock;

  afs_core i_dut (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .cmp_a_result(cmp_a_result), .cmp_b_result(cmp_b_result),
    .analog(analog), .pins(pins), .irq_req(irq_req));
  afs_far_model i_far (.analog(analog), .lvl_a(lvl_a), .lvl_b(lvl_b),
    .cmp_a_result(cmp_a_result), .cmp_b_result(cmp_b_result));

  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one bus cycle: request after an edge, held until waitrequest low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    read <= ~w;
    write <= w;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc

  // write, then let analog outputs settle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    repeat (2) @(negedge clock);
  endtask : wr

  task automatic level(input logic b, input logic v);
    @(posedge clock);
    if (b)
      lvl_b <= v;
    else
      lvl_a <= v;
    repeat (5) @(negedge clock);
  endtask : level

  task automatic t_reset;
    acc(1'b0, AFS_A_CAL, 8'h0);
    chk(q, 32'h10);
    acc(1'b0, AFS_A_PATH, 8'h0);
    chk(q, 32'h82);
    acc(1'b0, AFS_B_CAL, 8'h0);
    chk(q, 32'h10);
    acc(1'b0, AFS_B_PATH, 8'h0);
    chk(q, 32'h02);
    acc(1'b0, 4'h9, 8'h0);
    chk(q, 32'h0);
    chk({30'h0, r}, 32'h2);
    chk({analog.cmp_a_trim, analog.cmp_b_trim}, 10'h210);
    chk({analog.cmp_a_en, analog.cmp_b_en, pins.a_oe, pins.b_oe}, 4'h0);
  endtask : t_reset

  task automatic t_amp;
    wr(AFS_AMP_CTRL, 8'h0e);
    chk({analog.gain_switch_a, analog.gain_switch_b, analog.buffer_feedback_switch}, 0);
    chk({analog.pin_pos_claim, analog.pin_neg_claim, analog.pin_out_claim}, 0);
    wr(AFS_AMP_CTRL, 8'h0f);
    chk({analog.gain_switch_a, analog.gain_switch_b}, 2'h3);
    chk({analog.pin_pos_claim, analog.pin_neg_claim, analog.pin_out_claim}, 3'h7);
    chk(analog.bypass_resistor, 1'b1);
    wr(AFS_AMP_CTRL, 8'h03);
    chk({analog.pin_pos_claim, analog.pin_neg_claim, analog.pin_out_claim}, 3'h3);
    chk(analog.bypass_resistor, 1'b0);
    wr(AFS_AMP_CTRL, 8'h01);
    chk({analog.gain_switch_a, analog.gain_switch_b, analog.pin_neg_claim}, 0);
  endtask : t_amp

  task automatic t_cal;
    wr(AFS_A_PATH, 8'h01);
    chk({analog.shared_positive_select, analog.cmp_a_neg_select}, 2'h0);
    wr(AFS_A_CAL, 8'h60);
    acc(1'b0, AFS_A_PATH, 8'h0);
    chk(q, 32'h83);
    chk({analog.shared_positive_select, analog.cmp_a_neg_select}, 2'h3);
    chk({analog.cmp_a_ref, analog.cmp_a_trim}, 6'h20);
    wr(AFS_A_CAL, 8'h05);
    acc(1'b0, AFS_A_PATH, 8'h0);
    chk(q, 32'h01);
    chk({analog.cmp_a_ref, analog.cmp_a_trim}, 6'h05);
    wr(AFS_B_PATH, 8'h01);
    wr(AFS_B_CAL, 8'h40);
    acc(1'b0, AFS_B_PATH, 8'h0);
    chk(q, 32'h03);
    chk({analog.shared_positive_select, analog.cmp_b_ref}, 2'h2);
    wr(AFS_B_CAL, 8'h20);
    chk({analog.shared_positive_select, analog.cmp_b_pos_select}, 2'h0);
  endtask : t_cal

  task automatic t_route;
    wr(AFS_AMP_CTRL, 8'h41);
    chk(analog.amp_b_route, 1'b1);
    wr(AFS_A_PATH, 8'h81);
    chk({analog.amp_a_route, analog.amp_b_route}, 2'h0);
  endtask : t_route

  task automatic t_irq;
    logic [1:0] m;
    wr(AFS_A_PATH, 8'h0d);
    level(1'b0, 1'b1);
    acc(1'b0, AFS_A_CAL, 8'h0);
    chk(q, 32'h85);
    chk({pins.a_out, pins.a_oe}, 2'h3);
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      wr(AFS_B_PATH, {m, 6'h0d});
      wr(AFS_IRQ_STAT, 8'h03);
      level(1'b1, 1'b1);
      chk({irq_req[1], pins.b_out, pins.b_oe}, {m[0], 2'h3});
      wr(AFS_IRQ_STAT, 8'h02);
      level(1'b1, 1'b0);
      chk(irq_req[1], m[1]);
    end
    wr(AFS_B_PATH, 8'hc5);
    wr(AFS_IRQ_STAT, 8'h02);
    level(1'b1, 1'b1);
    chk(irq_req[1], 1'b0);
    wr(AFS_A_PATH, 8'h05);
    level(1'b0, 1'b0);
    chk(irq_req[0], 1'b0);
    wr(AFS_A_PATH, 8'h0d);
    wr(AFS_IRQ_STAT, 8'h01);
    level(1'b0, 1'b1);
    chk(irq_req[0], 1'b1);
  endtask : t_irq

  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_amp();
    t_cal();
    t_route();
    t_irq();
    final_report();
  end
endmodule : afs_core_tb
